// ---- rtl/rxfws_top.sv ----
// Top: receive filter event flags with register port and interrupt
//
// Contract
// RQ1 - SFD error sets bit 7, read clears
// RQ2 - CRC failure latches bit 6 until read
// RQ3 - Unicast frame latches bit 4, read clears
// RQ4 - Broadcast frame latches bit 2, read clears
// RQ5 - Pattern match latches bit 1, read clears
// RQ6 - Magic packet latches bit 0, read clears
// RQ7 - Status word at 135h, zero after reset
// RQ8 - Bits 15-8, 5, 3 read zero
// RQ9 - Software enables feature bit before use
// RQ10 - Wake events interrupt only when enabled
// RQ11 - Event coinciding with read clear not lost
`timescale 1ns/1ps
`default_nettype none
module rxfws_top
    import rxfws_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [RXFWS_ADDR_W-1:0] reg_addr,
    input wire logic [RXFWS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [RXFWS_DATA_W-1:0] reg_rdata,
    input wire logic ev_delimiter_error,
    input wire logic ev_bad_crc,
    input wire logic ev_single_dest,
    input wire logic ev_all_dest,
    input wire logic ev_match,
    input wire logic ev_wake_magic,
    output logic irq
);

    rxfws_bus_if bus ();

    // ************************************************************
    // Address decode
    // ************************************************************
    wire hit_flags = reg_addr == RXFWS_OFS_FLAGS;
    wire hit_cfg = reg_addr == RXFWS_OFS_CFG;
    wire hit_mask = reg_addr == RXFWS_OFS_MASK;
    wire wr_cfg = reg_wr & hit_cfg;
    wire wr_mask = reg_wr & hit_mask;

    // A read of the status word clears it; writes to it are ignored
    assign bus.rd_flags = reg_rd & hit_flags; // see RQ8

    // ************************************************************
    // Configuration and mask registers
    // ************************************************************
    logic [15:0] cfg_r;
    logic [7:0] mask_r;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg_r <= RXFWS_RST_CFG;
            mask_r <= RXFWS_RST_MASK;
        end
        else
        begin
            if (wr_cfg)
                cfg_r <= reg_wdata;
            if (wr_mask)
                mask_r <= reg_wdata[7:0];
        end
    end

    // ************************************************************
    // Event gathering
    // ************************************************************
    // Features stay quiet until software sets the enable, so stale
    // filter output cannot raise flags before configuration.
    wire feat_en = cfg_r[RXFWS_BIT_FEAT]; // see RQ9
    logic [7:0] ev_raw;
    always_comb
    begin
        ev_raw = 8'h00;
        ev_raw[RXFWS_BIT_SFD] = ev_delimiter_error; // see RQ1
        ev_raw[RXFWS_BIT_CRC] = ev_bad_crc; // see RQ2
        ev_raw[RXFWS_BIT_UCAST] = ev_single_dest; // see RQ3
        ev_raw[RXFWS_BIT_BCAST] = ev_all_dest; // see RQ4
        ev_raw[RXFWS_BIT_PATTERN] = ev_match; // see RQ5
        ev_raw[RXFWS_BIT_MAGIC] = ev_wake_magic; // see RQ6
    end
    assign bus.ev = ev_raw & {8{feat_en}};

    rxfws_flag_bank u_bank
    (
        .clk(clk),
        .rst_n(rst_n),
        .bus(bus)
    );

    // ************************************************************
    // Read data, one cycle after the strobe
    // ************************************************************
    wire [15:0] rd_mux = hit_flags ? {8'h00, bus.flags} : // see RQ7
                         hit_cfg ? cfg_r :
                         hit_mask ? {8'h00, mask_r} : RXFWS_ZERO;
    logic [15:0] rdata_r;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_r <= RXFWS_ZERO;
        else
            rdata_r <= reg_rd ? rd_mux : RXFWS_ZERO;
    end
    assign reg_rdata = rdata_r;

    // ************************************************************
    // Interrupt: wake-type bits need their enable, others pass
    // ************************************************************
    wire [7:0] irq_gate = ~RXFWS_WAKE_GATED | cfg_r[7:0]; // see RQ10
    assign irq = |(bus.flags & mask_r & irq_gate);

    // ************************************************************
    // Checks
    // ************************************************************
    // All checks live in the one clock domain and sleep during reset
    default clocking cb_chk @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_read_flags;
        reg_rd && hit_flags;
    endsequence

    // Feature off and nothing latched: raw events must not reach the flags
    sequence s_gated_idle;
        !feat_en && bus.flags == 8'h00;
    endsequence

    a_upper_zero: assert property (reg_rdata[15:8] == 8'h00 || $past(hit_cfg)) // see RQ8
        else $error("upper status byte not zero");
    a_rsvd_zero: assert property (s_read_flags |=> !reg_rdata[5] && !reg_rdata[3]) // see RQ8
        else $error("reserved status bit set");
    a_sfd_seen: assert property ((ev_delimiter_error && feat_en) ##1 s_read_flags |=> reg_rdata[7]) // see RQ1
        else $error("delimiter error not reported");
    a_crc_seen: assert property ((ev_bad_crc && feat_en) ##1 s_read_flags |=> reg_rdata[6]) // see RQ2
        else $error("bad check not reported");
    a_ucast_seen: assert property ((ev_single_dest && feat_en) ##1 s_read_flags |=> reg_rdata[4]) // see RQ3
        else $error("unicast not reported");
    a_bcast_seen: assert property ((ev_all_dest && feat_en) ##1 s_read_flags |=> reg_rdata[2]) // see RQ4
        else $error("broadcast not reported");
    a_match_seen: assert property ((ev_match && feat_en) ##1 s_read_flags |=> reg_rdata[1]) // see RQ5
        else $error("pattern match not reported");
    a_magic_seen: assert property ((ev_wake_magic && feat_en) ##1 s_read_flags |=> reg_rdata[0]) // see RQ6
        else $error("magic packet not reported");
    a_read_clears: assert property ((s_read_flags and !(|bus.ev)) |=> bus.flags == 8'h00) // see RQ7
        else $error("read did not clear flags");
    a_ucast_gated: assert property (!cfg_r[4] && bus.flags == 8'h10 |-> !irq) // see RQ10
        else $error("unicast interrupt without enable");
    a_crc_irq: assert property (bus.flags[RXFWS_BIT_CRC] && mask_r[RXFWS_BIT_CRC] |-> irq) // see RQ2
        else $error("unmasked check error gives no interrupt");
    a_gate_holds: assert property (s_gated_idle |=> bus.flags == 8'h00) // see RQ9
        else $error("flag rose while feature disabled");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == RXFWS_ZERO) // see RQ7
        else $error("read data outside read cycle");

endmodule
`default_nettype wire

// ---- rtl/rxfws_pkg.sv ----
// Package: register map, field positions and reset values of the receive filter status block
package rxfws_pkg;

    localparam int RXFWS_ADDR_W = 9;
    localparam int RXFWS_DATA_W = 16;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [8:0] RXFWS_OFS_FLAGS = 9'h135;
    localparam logic [8:0] RXFWS_OFS_CFG = 9'h134;
    localparam logic [8:0] RXFWS_OFS_MASK = 9'h136;

    // ************************************************************
    // Status bit positions
    // ************************************************************
    localparam int RXFWS_BIT_MAGIC = 0;
    localparam int RXFWS_BIT_PATTERN = 1;
    localparam int RXFWS_BIT_BCAST = 2;
    localparam int RXFWS_BIT_UCAST = 4;
    localparam int RXFWS_BIT_CRC = 6;
    localparam int RXFWS_BIT_SFD = 7;
    localparam int RXFWS_BIT_FEAT = 7;
    localparam int RXFWS_NUM_EV = 8;

    // Implemented flag bits; 5 and 3 reserved, upper byte zero
    localparam logic [7:0] RXFWS_FLAG_IMPL = 8'hD7;
    // Events gated by the wake enables in the configuration word
    localparam logic [7:0] RXFWS_WAKE_GATED = 8'h17;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] RXFWS_RST_FLAGS = 16'h0000;
    localparam logic [15:0] RXFWS_RST_CFG = 16'h0000;
    localparam logic [7:0] RXFWS_RST_MASK = 8'hFF;
    localparam logic [15:0] RXFWS_ZERO = 16'h0000;

endpackage

// ---- rtl/rxfws_bus_if.sv ----
// Interface: internal register strobe group shared by the top and the flag bank
`timescale 1ns/1ps
`default_nettype none
interface rxfws_bus_if;
    logic rd_flags;
    logic [7:0] ev;
    logic [7:0] flags;

    modport ctrl
    (
        output rd_flags,
        output ev,
        input flags
    );
    modport bank
    (
        input rd_flags,
        input ev,
        output flags
    );
endinterface
`default_nettype wire

// ---- rtl/rxfws_flag_bank.sv ----
// Flag bank: sticky clear-on-read event flags, one per event bit
`timescale 1ns/1ps
`default_nettype none
module rxfws_flag_bank
    import rxfws_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    rxfws_bus_if.bank bus
);

    // ************************************************************
    // One sticky flag per bit; reserved bits are never built
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < RXFWS_NUM_EV; gi++)
        begin : g_flag
            if (RXFWS_FLAG_IMPL[gi])
            begin : g_impl
                logic flag_r;
                logic flag_nxt;
                // Set beats the read clear so a coincident event survives
                assign flag_nxt = bus.ev[gi] | (flag_r & ~bus.rd_flags); // see RQ11
                always_ff @(posedge clk)
                begin
                    if (!rst_n)
                        flag_r <= RXFWS_RST_FLAGS[gi];
                    else
                        flag_r <= flag_nxt;
                end
                assign bus.flags[gi] = flag_r;
                a_flag_set_survives: assert property (@(posedge clk) disable iff (!rst_n) // see RQ11
                    bus.ev[gi] |=> flag_r)
                    else $error("flag lost an event");
            end
            else
            begin : g_rsvd
                assign bus.flags[gi] = 1'b0; // see RQ8
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Testbench: register port, sticky flags, clear-on-read and interrupt of the receive filter status block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rxfws_pkg::*;
;
    logic clk;
    logic rst_n;
    logic [8:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic [5:0] ev;
    logic irq;
    logic [15:0] got;
    int n_errors;
    int checked;
    int cycles;
    int pos[6] = '{0, 1, 2, 4, 6, 7};

    rxfws_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_delimiter_error(ev[5]), .ev_bad_crc(ev[4]),
        .ev_single_dest(ev[3]), .ev_all_dest(ev[2]), .ev_match(ev[1]), .ev_wake_magic(ev[0]), .irq(irq));

    // ********************************************************
    // Clock, timeout and bus tasks
    // ********************************************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Cut a hang short; the whole run needs about a hundred cycles
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            n_errors = n_errors + 1;
            test_done();
        end
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked = checked + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [8:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        got = reg_rdata;
    endtask

    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 6'b00_0000;
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    // Each event alone sets only its own bit; the read follows the event at once, and one read clears it
    task automatic t_each_flag();
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            ev <= 6'(1 << i);
            @(posedge clk);
            ev <= 6'b00_0000;
            reg_addr <= RXFWS_OFS_FLAGS;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            chk(reg_rdata, 16'(1 << pos[i]));
            rd(RXFWS_OFS_FLAGS);
            chk(got, 16'h0000);
        end
    endtask

    // Writes to the status word change nothing; upper byte and reserved bits stay zero
    task automatic t_reserved();
        pulse(6'b11_1111);
        wr(RXFWS_OFS_FLAGS, 16'hFFFF);
        rd(RXFWS_OFS_FLAGS);
        chk(got, 16'h00D7);
        rd(9'h1FF);
        chk(got, 16'h0000);
    endtask

    // An event landing on the clearing read must survive into the next read
    task automatic t_set_beats_clear();
        pulse(6'b00_0001);
        @(posedge clk);
        reg_addr <= RXFWS_OFS_FLAGS;
        reg_rd <= 1'b1;
        ev <= 6'b00_1000;
        @(posedge clk);
        reg_rd <= 1'b0;
        ev <= 6'b00_0000;
        #1;
        chk(reg_rdata, 16'h0001);
        rd(RXFWS_OFS_FLAGS);
        chk(got, 16'h0010);
    endtask

    // Wake events interrupt only with their enable; the CRC error flag follows the mask alone
    task automatic t_irq();
        wr(RXFWS_OFS_CFG, 16'h0080);
        pulse(6'b00_1111);
        #1;
        chk(16'(irq), 16'h0000);
        pulse(6'b01_0000);
        #1;
        chk(16'(irq), 16'h0001);
        wr(RXFWS_OFS_MASK, 16'h0000);
        #1;
        chk(16'(irq), 16'h0000);
        wr(RXFWS_OFS_MASK, 16'h00FF);
        rd(RXFWS_OFS_FLAGS);
        chk(got, 16'h0057);
        wr(RXFWS_OFS_CFG, 16'h0097);
        for (int i = 0; i < 4; i++)
        begin
            pulse(6'(1 << i));
            #1;
            chk(16'(irq), 16'h0001);
            rd(RXFWS_OFS_FLAGS);
            #1;
            chk(16'(irq), 16'h0000);
        end
    endtask

    // A mid-run reset empties the flags and restores cfg and mask; events stay ignored while the feature is off
    task automatic t_reset();
        pulse(6'b11_0001);
        wr(RXFWS_OFS_MASK, 16'h0011);
        #1;
        chk(16'(irq), 16'h0001);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(16'(irq), 16'h0000);
        rd(RXFWS_OFS_FLAGS);
        chk(got, 16'h0000);
        rd(RXFWS_OFS_CFG);
        chk(got, 16'h0000);
        rd(RXFWS_OFS_MASK);
        chk(got, 16'h00FF);
        pulse(6'b11_1111);
        rd(RXFWS_OFS_FLAGS);
        chk(got, 16'h0000);
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        n_errors = 0;
        checked = 0;
        cycles = 0;
        rst_n = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ev = 6'b00_0000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(RXFWS_OFS_FLAGS);
        chk(got, 16'h0000);
        wr(RXFWS_OFS_CFG, 16'h0080);
        t_each_flag();
        t_reserved();
        t_set_beats_clear();
        t_irq();
        t_reset();
        test_done();
    end
endmodule
`default_nettype wire
